//--- src/fbp_pkg.sv
// Package of constants and types for the flash buffered program host controller.
package fbp_pkg;
  // ==========================================================================
  // Command codes
  // ==========================================================================
  localparam logic [7:0] CMD_CONFIRM = 8'h29;
  localparam logic [7:0] CMD_ABORT_RESET = 8'hF0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_ENH_BYPASS = 8'h33;
  localparam logic [7:0] CMD_WBUF_SETUP = 8'h25;
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_ENH_SETUP = 8'h33;
  localparam logic [22:0] ADDR_UNLOCK1 = 23'h000555;
  localparam logic [22:0] ADDR_UNLOCK2 = 23'h0002AA;
  // ==========================================================================
  // Sizes and status bits
  // ==========================================================================
  localparam int WBUF_WORDS = 32;
  localparam int ENH_WORDS = 256;
  localparam int ABORT_FLAG_BIT = 1;
  localparam int FAIL_FLAG_BIT = 5;
  localparam int TOGGLE_FLAG_BIT = 6;
  localparam int POLLING_FLAG_BIT = 7;
  // ==========================================================================
  // Bus timing
  // ==========================================================================
  localparam int CLK_MHZ = 40;
  localparam int T_WP_NS = 50;
  localparam int T_RD_NS = 80;
  localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int RD_CYC = (T_RD_NS * CLK_MHZ + 999) / 1000;
  // ==========================================================================
  // Own register map
  // ==========================================================================
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hC;
  localparam logic [2:0] OP_WRITE = 3'h0;
  localparam logic [2:0] OP_READ = 3'h1;
  localparam logic [2:0] OP_CMD = 3'h2;
  localparam logic [2:0] OP_ABORT_RESET = 3'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [22:0] addr;
    logic [15:0] dout;
    logic dq_oe_n;
    logic ce_n;
    logic we_n;
    logic oe_n;
  } fbp_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WSET = 3'b001,
    ST_WPUL = 3'b010,
    ST_WREC = 3'b011,
    ST_RPUL = 3'b100,
    ST_DONE = 3'b101
  } fbp_state_t;
endpackage : fbp_pkg

//--- src/fbp_host.sv
// Host controller that drives buffered program and suspend sequences on a parallel flash bus.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Confirm 29h programs loaded n+1 words
// - F0h abort-and-reset returns to read mode
// - Bypass mode needs full three-cycle abort
// - Enhanced flow: setup, 256 loads, confirm
// - Enhanced loads ascend A[7:0] without gaps
// - Fail needs reset, abort needs F0h
module fbp_host
  import fbp_pkg::*;
#(
  parameter int BUF_WORDS = WBUF_WORDS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output fbp_pins_t flash_pins,
  input wire logic [15:0] flash_dq_in
);
  initial begin
    if (BUF_WORDS < 1 || BUF_WORDS > WBUF_WORDS) $error("BUF_WORDS out of range");
  end

  // ==========================================================================
  // Register and bus state
  // ==========================================================================
  fbp_state_t st_reg, st_next;
  fbp_pins_t pins_reg, pins_next;
  logic [22:0] addr_reg, addr_next;
  logic [15:0] data_reg, data_next;
  logic [15:0] rd_reg, rd_next;
  logic [2:0] op_reg, op_next;
  logic [1:0] step_reg, step_next;
  logic [3:0] cnt_reg, cnt_next;
  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [3:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next;
  logic bvalid_reg, bvalid_next, arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] bresp_reg, bresp_next;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic [22:0] cyc_addr;
  logic [15:0] cyc_data;
  logic cyc_read;

  // Address and data of each step of a multi-cycle operation.
  always_comb begin
    cyc_addr = addr_reg;
    cyc_data = data_reg;
    cyc_read = 1'b0;
    case (op_reg)
      OP_READ: cyc_read = 1'b1;
      OP_ABORT_RESET: begin
        case (step_reg)
          2'd0: begin
            cyc_addr = ADDR_UNLOCK1;
            cyc_data = {8'h00, CMD_UNLOCK1};
          end
          2'd1: begin
            cyc_addr = ADDR_UNLOCK2;
            cyc_data = {8'h00, CMD_UNLOCK2};
          end
          default: begin
            cyc_addr = ADDR_UNLOCK1;
            cyc_data = {8'h00, CMD_ABORT_RESET};
          end
        endcase
      end
      default: ;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    pins_next = pins_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    rd_next = rd_reg;
    op_next = op_reg;
    step_next = step_reg;
    cnt_next = cnt_reg;
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    awa_next = awa_reg;
    wd_next = wd_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    arready_next = 1'b0;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_got_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_got_next = 1'b1;
      wd_next = s_axi_wdata;
    end
    if (bvalid_reg && s_axi_bready) bvalid_next = 1'b0;
    if (aw_got_reg && w_got_reg && !bvalid_reg && st_reg == ST_IDLE) begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      case (awa_reg)
        REG_ADDR: addr_next = wd_reg[22:0];
        REG_DATA: data_next = wd_reg[15:0];
        REG_CTRL: begin
          // Start one bus operation; commands 29h, B0h, 30h, 33h, 25h go as OP_CMD data.
          step_next = 2'd0;
          // Only a valid op is kept, so a refused one cannot block later cycles.
          if (wd_reg[2:0] <= OP_ABORT_RESET) begin
            op_next = wd_reg[2:0];
            st_next = ST_WSET;
          end else bresp_next = RESP_SLVERR;
        end
        default: bresp_next = RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && !arready_reg && !rvalid_reg) begin
      arready_next = 1'b1;
      rvalid_next = 1'b1;
      case (s_axi_araddr)
        REG_ADDR: rdata_next = {9'h000, addr_reg};
        REG_DATA: rdata_next = {16'h0000, data_reg};
        REG_CTRL: rdata_next = {29'h0, op_reg};
        // Status word: busy, abort, fail, toggle, polling bits of last read.
        REG_STAT: rdata_next = {11'h0, rd_reg[POLLING_FLAG_BIT], rd_reg[TOGGLE_FLAG_BIT], rd_reg[FAIL_FLAG_BIT],
                                rd_reg[ABORT_FLAG_BIT], (st_reg != ST_IDLE), rd_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    if (rvalid_reg && s_axi_rready) rvalid_next = 1'b0;
    case (st_reg)
      ST_IDLE: begin
        pins_next.ce_n = 1'b1;
        pins_next.we_n = 1'b1;
        pins_next.oe_n = 1'b1;
        pins_next.dq_oe_n = 1'b1;
      end
      ST_WSET: begin
        pins_next.addr = cyc_addr;
        pins_next.dout = cyc_data;
        pins_next.ce_n = 1'b0;
        cnt_next = 4'(cyc_read ? RD_CYC : WP_CYC);
        if (cyc_read) begin
          pins_next.oe_n = 1'b0;
          st_next = ST_RPUL;
        end else begin
          pins_next.dq_oe_n = 1'b0;
          pins_next.we_n = 1'b0;
          st_next = ST_WPUL;
        end
      end
      ST_WPUL: begin
        if (cnt_reg > 4'd1) cnt_next = cnt_reg - 4'd1;
        else begin
          pins_next.we_n = 1'b1;
          st_next = ST_WREC;
        end
      end
      ST_WREC: begin
        pins_next.ce_n = 1'b1;
        pins_next.dq_oe_n = 1'b1;
        if (op_reg == OP_ABORT_RESET && step_reg != 2'd2) begin
          step_next = step_reg + 2'd1;
          st_next = ST_WSET;
        end else st_next = ST_DONE;
      end
      ST_RPUL: begin
        if (cnt_reg > 4'd1) cnt_next = cnt_reg - 4'd1;
        else begin
          rd_next = flash_dq_in;
          pins_next.oe_n = 1'b1;
          pins_next.ce_n = 1'b1;
          st_next = ST_DONE;
        end
      end
      ST_DONE: st_next = ST_IDLE;
      default: st_next = ST_IDLE;
    endcase
    // Ready is registered and offered only while no capture or response is pending.
    awready_next = !aw_got_next && !bvalid_next;
    wready_next = !w_got_next && !bvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= ST_IDLE;
      pins_reg <= '{addr: 23'h0, dout: 16'h0, dq_oe_n: 1'b1, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
      addr_reg <= 23'h0;
      data_reg <= 16'h0;
      rd_reg <= 16'h0;
      op_reg <= OP_WRITE;
      step_reg <= 2'd0;
      cnt_reg <= 4'h0;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awa_reg <= 4'h0;
      wd_reg <= 32'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      st_reg <= st_next;
      pins_reg <= pins_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      rd_reg <= rd_next;
      op_reg <= op_next;
      step_reg <= step_next;
      cnt_reg <= cnt_next;
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = RESP_OKAY;
  assign flash_pins = pins_reg;
endmodule : fbp_host
`default_nettype wire

//--- dv/fbp_host_assertions.sv
// Concurrent checks on the host controller's flash pins and read channel.
`timescale 1ns/1ps
`default_nettype none
module fbp_host_assertions
  import fbp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire fbp_pins_t flash_pins
);
  // ======
  // Checks
  wire logic we = flash_pins.we_n;
  wire logic ce = flash_pins.ce_n;
  wire logic oe = flash_pins.oe_n;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_WE_PULSE: assert property ($fell(we) |-> (!we) [*2] ##1 we) else $error("write strobe width");
  AST_WE_QUAL: assert property (!we |-> !ce && !flash_pins.dq_oe_n && oe) else $error("write qualifiers");
  AST_WR_HOLD: assert property (!we && !$past(we) |-> $stable(flash_pins.addr) && $stable(flash_pins.dout))
    else $error("write cycle moved");
  AST_RD_CLEAN: assert property (!oe |-> we && !ce && flash_pins.dq_oe_n) else $error("read qualifiers");
  AST_ABORT_TRIO: assert property ($rose(we) && flash_pins.dout[7:0] == CMD_UNLOCK1 && flash_pins.addr == ADDR_UNLOCK1
    |-> ##[1:60] ($fell(we) && flash_pins.dout[7:0] == CMD_UNLOCK2 && flash_pins.addr == ADDR_UNLOCK2))
    else $error("abort sequence cut short");
  AST_ABORT_F0: assert property ($rose(we) && flash_pins.dout[7:0] == CMD_UNLOCK2 && flash_pins.addr == ADDR_UNLOCK2
    |-> ##[1:60] ($fell(we) && flash_pins.dout[7:0] == CMD_ABORT_RESET)) else $error("abort code missing");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  cover property ($rose(we) && flash_pins.dout[7:0] == CMD_CONFIRM);
  cover property ($fell(we) && flash_pins.dout[7:0] == CMD_ABORT_RESET);
  cover property ($fell(oe));
  cover property ($fell(we) && flash_pins.dout[7:0] == CMD_SUSPEND);
endmodule : fbp_host_assertions
bind fbp_host fbp_host_assertions u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .flash_pins(flash_pins));
`default_nettype wire

//--- dv/fbp_flash_model.sv
// Behavioural flash device answering the host's bus cycles.
`timescale 1ns/1ps
`default_nettype none
module fbp_flash_model
  import fbp_pkg::*;
(
  input wire fbp_pins_t p,
  output logic [15:0] dq
);
  // ======
  // Command state
  logic [15:0] mem [int];
  logic [15:0] buff [int];
  logic [15:0] last = 16'h0000;
  logic tog = 1'b0;
  logic [22:0] base;
  int st = 0;
  int cnt;
  int idx;
  int pend;
  always @(posedge p.we_n) if (!p.ce_n) begin
    case (st)
      0: begin
        base = p.addr;
        idx = 0;
        buff.delete();
        if (p.dout[7:0] == CMD_WBUF_SETUP) st = 1;
        if (p.dout[7:0] == CMD_ENH_SETUP) st = 3;
      end
      1: begin
        cnt = int'(p.dout);
        st = (cnt >= WBUF_WORDS) ? 9 : 2;
      end
      2, 3: begin
        last = p.dout;
        buff[p.addr] = p.dout;
        if (st == 2 ? p.addr[22:5] != base[22:5] : p.addr != {base[22:8], idx[7:0]}) st = 9;
        else if (idx == (st == 2 ? cnt : ENH_WORDS - 1)) st = 4;
        else idx++;
      end
      4: begin
        pend = 3;
        st = (p.dout[7:0] == CMD_CONFIRM) ? 5 : 9;
      end
      5: if (p.dout[7:0] == CMD_SUSPEND) st = 6;
      6: if (p.dout[7:0] == CMD_RESUME) st = 5;
      9: if (p.dout[7:0] == CMD_ABORT_RESET) st = 0;
      default: st = 0;
    endcase
  end
  // The status word flips its toggle bit once per read while aborted or programming.
  always @(negedge p.oe_n) if (st == 9 || st == 5) tog = ~tog;
  // Programming lasts three status reads, and the buffer lands in the array at the end.
  always @(posedge p.oe_n) if (st == 5) begin
    pend--;
    if (pend == 0) begin
      foreach (buff[a]) mem[a] = buff[a];
      st = 0;
    end
  end
  function automatic logic [15:0] rdv();
    if (st == 9) return {8'h00, ~last[7], tog, 4'h0, 2'b10};
    // A word whose programming is suspended reads as status, not as data.
    if (st == 5 || (st == 6 && buff.exists(p.addr))) return {8'h00, ~last[7], tog, 6'h00};
    return mem.exists(p.addr) ? mem[p.addr] : 16'hFFFF;
  endfunction : rdv
  // Released bus shows a changing pattern instead of stale data.
  always @(p, st, tog) dq = (!p.ce_n && !p.oe_n) ? rdv() : ~dq;
endmodule : fbp_flash_model
`default_nettype wire

//--- dv/flash_buffered_program_suspend_test.sv
// Self-checking bench for the flash buffered program host controller.
`timescale 1ns/1ps
`default_nettype none
module flash_buffered_program_suspend_test
  import fbp_pkg::*;
;
  // ======
  // Bench state
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rd, s1;
  logic [1:0] bresp, rresp, r;
  logic [15:0] dq, lastd;
  logic [15:0] bufd [256];
  logic [15:0] ref_m [int];
  logic [22:0] a0;
  fbp_pins_t pins;
  int miscompares = 0, check_count = 0, seed = 32'hA945, n;
  fbp_host uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flash_pins(pins), .flash_dq_in(dq));
  fbp_flash_model u_dev (.p(pins), .dq(dq));
  initial forever #12.5 aclk = ~aclk;
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic guard(input int k);
    if (k > 400) begin
      $display("[ERR] %0t wait limit reached", $time);
      miscompares++;
      report_and_stop();
    end
  endtask : guard
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      $display("[ERR] %0t got %h expected %h", $time, g, e);
      miscompares++;
    end
  endtask : chk
  task automatic axi(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge aclk);
    {awaddr, araddr, wdata} <= {a, a, d};
    // Reads of the unmapped offset 6 hold rready back so that the read data must stand.
    {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w && a != 4'h6};
    do begin
      @(posedge aclk);
      guard(++k);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
      if (arready && !w && !rready) rready <= 1'b1;
    end while ((w ? bvalid : rvalid && rready) !== 1'b1);
    if (w) r = bresp;
    else {rd, r} = {rdata, rresp};
    {bready, rready} <= 2'b00;
  endtask : axi
  task automatic fop(input logic [2:0] op, input logic [22:0] a, input logic [15:0] d);
    int k = 0;
    axi(1'b1, REG_DATA, {16'h0000, d});
    axi(1'b1, REG_ADDR, {9'h000, a});
    axi(1'b1, REG_CTRL, {29'h0, op});
    do begin
      axi(1'b0, REG_STAT, 32'h0);
      guard(++k);
    end while (rd[16] !== 1'b0);
  endtask : fop
  task automatic ld(input logic [22:0] a, input logic [15:0] d);
    fop(OP_WRITE, a, d);
    lastd = d;
  endtask : ld
  task automatic rdchk(input logic [22:0] a);
    fop(OP_READ, a, 16'h0);
    chk(32'(rd[15:0]), 32'(ref_m.exists(a) ? ref_m[a] : 16'hFFFF));
  endtask : rdchk
  task automatic wait_prog(input logic [22:0] a);
    int k = 0;
    do begin
      fop(OP_READ, a, 16'h0);
      s1 = rd;
      fop(OP_READ, a, 16'h0);
      guard(++k);
    end while (s1[6] !== rd[6]);
  endtask : wait_prog
  task automatic abort_chk();
    fop(OP_READ, a0, 16'h0);
    s1 = rd;
    fop(OP_READ, a0, 16'h0);
    chk(32'({s1[20:17], rd[19]}), 32'({~lastd[7], s1[19], 2'b01, ~s1[19]}));
    fop(OP_ABORT_RESET, a0, 16'h0);
    rdchk(a0);
  endtask : abort_chk
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi(1'b1, 4'h2, 32'h0);
    chk(32'(r), 32'(RESP_SLVERR));
    axi(1'b1, REG_CTRL, 32'h5);
    chk(32'(r), 32'(RESP_SLVERR));
    axi(1'b0, 4'h6, 32'h0);
    chk(rd, 32'h0);
    chk(32'(r), 32'(RESP_OKAY));
    $display("[T] bus done");
    for (int t = 0; t < 4; t++) begin
      n = (t == 0) ? 31 : (t == 1) ? 0 : ($random(seed) & 31);
      a0 = 23'($random(seed)) & 23'h7FFFE0;
      fop(OP_CMD, a0, 16'(CMD_WBUF_SETUP));
      fop(OP_CMD, a0, 16'(n));
      for (int i = 0; i <= n; i++) begin
        bufd[i] = 16'($random(seed));
        ld(a0 + 23'(i), bufd[i]);
        ref_m[a0 + 23'(i)] = bufd[i];
      end
      fop(OP_CMD, a0, 16'(CMD_CONFIRM));
      if (t == 0) begin
        fop(OP_CMD, a0, 16'(CMD_SUSPEND));
        rdchk(a0 ^ 23'h400);
        fop(OP_CMD, a0, 16'(CMD_RESUME));
        fop(OP_CMD, a0, 16'(CMD_RESUME));
        fop(OP_READ, a0, 16'h0);
        chk(32'({rd[20], rd[18:17]}), 32'({~lastd[7], 2'b00}));
      end
      wait_prog(a0);
      for (int i = 0; i <= n; i++) rdchk(a0 + 23'(i));
    end
    $display("[T] buffer program done");
    for (int t = 0; t < 4; t++) begin
      fop(OP_CMD, a0, 16'(t == 3 ? CMD_ENH_SETUP : CMD_WBUF_SETUP));
      if (t < 3) fop(OP_CMD, a0, t == 0 ? 16'(WBUF_WORDS) : 16'h0001);
      if (t == 1) ld(a0 + 23'h20, 16'h1234);
      if (t == 2) ld(a0, 16'h00C5);
      if (t == 2) ld(a0 + 23'h1, 16'h5A5A);
      if (t == 2) fop(OP_CMD, a0, 16'h0000);
      if (t == 3) ld(a0 + 23'h1, 16'h8001);
      abort_chk();
    end
    $display("[T] abort done");
    a0 = 23'($random(seed)) & 23'h7FFF00;
    fop(OP_CMD, a0, 16'(CMD_ENH_SETUP));
    for (int i = 0; i < ENH_WORDS; i++) begin
      bufd[i] = 16'($random(seed));
      ld(a0 | 23'(i), bufd[i]);
      ref_m[a0 | 23'(i)] = bufd[i];
    end
    fop(OP_CMD, a0, 16'(CMD_CONFIRM));
    wait_prog(a0);
    for (int i = 0; i < ENH_WORDS; i += 85) rdchk(a0 | 23'(i));
    $display("[T] enhanced done");
    report_and_stop();
  end
endmodule : flash_buffered_program_suspend_test
`default_nettype wire
